// ==== logic/nvac_ctrl.sv ====
// Purpose: byte access controller for a 512-byte nonvolatile array
// Assumes: I/O writes synchronous to clk, one register per io_sel value
// Notes: array contents are not cleared by reset
`timescale 1ns/1ps

// Functional notes
// [RULE1] array holds 512 bytes, addressed linearly 0 to 511
// [RULE2] nine-bit address over two registers; upper seven high bits read zero
// [RULE3] address must be loaded by software before any access
// [RULE4] data register gives write byte and receives read byte
// [RULE5] control register bits seven to four read zero
// [RULE6] ready interrupt is a level while enabled, global enable set, not busy
// [RULE7] unlock bit self-clears four cycles after software sets it
// [RULE8] write strobe starts a write only while unlock is set
// [RULE9] software waits idle, unlocks, then strobes within four cycles
// [RULE10] no write launches while flash self-programming is active
// [RULE11] write strobe stays set as busy until hardware ends the write
// [RULE12] write lasts 8448 ticks of a 1 MHz oscillator
// [RULE13] write launch stalls the processor two cycles
// [RULE14] read strobe fetches byte at once and stalls four cycles
// [RULE15] during a write, reads blocked and address writes ignored
// [RULE16] software should keep interrupts off through the write sequence
// [RULE17] writing zero to strobe bits does nothing
module nvac_ctrl #(
    parameter int OSC_DIV = nvac_pkg::OSC_DIV,
    parameter int WRITE_OSC_CYC = nvac_pkg::WRITE_OSC_CYC
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic [1:0] io_sel,
    input wire logic io_wr,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    input wire logic irq_global_en,
    input wire logic flash_selfprog_active,
    output logic cpu_stall,
    output logic nv_ready_irq
);
    logic [7:0] mem_r [0:nvac_pkg::ARRAY_BYTES-1];
    logic [8:0] nv_byte_address_r;
    logic [7:0] nv_data_byte_r;
    logic [7:0] wr_byte_r;
    logic ready_irq_enable_r;
    logic write_unlock_r;
    logic [2:0] unlock_cnt_r;
    logic [2:0] stall_cnt_r;
    logic addr_low_wr;
    logic addr_high_wr;
    logic data_wr;
    logic ctl_wr;
    logic unlock_req;
    logic wr_go;
    logic rd_go;
    logic write_strobe_busy;

    nvac_wr_if wr_if ();

    nvac_wr_timer #(
        .OSC_DIV(OSC_DIV),
        .WRITE_OSC_CYC(WRITE_OSC_CYC)
    ) u_timer (
        .clk(clk),
        .arst_n(arst_n),
        .ce(ce),
        .wr(wr_if.timer)
    );

    // register decode
    assign addr_low_wr = nvac_pkg::reg_hit(io_sel, nvac_pkg::REG_ADDR_LOW, io_wr);
    assign addr_high_wr = nvac_pkg::reg_hit(io_sel, nvac_pkg::REG_ADDR_HIGH, io_wr);
    assign data_wr = nvac_pkg::reg_hit(io_sel, nvac_pkg::REG_DATA, io_wr);
    assign ctl_wr = nvac_pkg::reg_hit(io_sel, nvac_pkg::REG_CONTROL, io_wr);
    assign unlock_req = ctl_wr && io_wdata[nvac_pkg::CTL_UNLOCK_BIT];

    // busy is the timer state seen through the strobe bit
    assign write_strobe_busy = wr_if.busy; // [RULE11]

    // launch needs live unlock, idle array and idle flash programming
    assign wr_go = ctl_wr && io_wdata[nvac_pkg::CTL_WRITE_BIT] && write_unlock_r // [RULE8]
                   && !write_strobe_busy && !flash_selfprog_active; // [RULE10]
    assign rd_go = ctl_wr && io_wdata[nvac_pkg::CTL_READ_BIT] && !write_strobe_busy; // [RULE15]
    assign wr_if.start = ce && wr_go;

    // address registers; ignored while a write runs
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            nv_byte_address_r <= nvac_pkg::ADDR_RESET; // [RULE3]
        else if (ce && !write_strobe_busy) // [RULE15]
        begin
            if (addr_low_wr)
                nv_byte_address_r[7:0] <= io_wdata;
            if (addr_high_wr)
                nv_byte_address_r[8] <= io_wdata[nvac_pkg::ADDR_HIGH_BIT]; // [RULE2]
        end
    end

    // data register: software byte or fetched byte
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            nv_data_byte_r <= nvac_pkg::DATA_RESET;
        else if (ce)
        begin
            if (rd_go)
                nv_data_byte_r <= mem_r[nv_byte_address_r]; // [RULE14] [RULE4]
            else if (data_wr)
                nv_data_byte_r <= io_wdata; // [RULE4]
        end
    end

    // byte held for the running write
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            wr_byte_r <= nvac_pkg::DATA_RESET;
        else if (ce && wr_go)
            wr_byte_r <= nv_data_byte_r; // [RULE4]
    end

    // array store at end of write
    always_ff @(posedge clk)
    begin
        if (ce && wr_if.done)
            mem_r[nv_byte_address_r] <= wr_byte_r; // [RULE1]
    end

    // interrupt enable bit
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            ready_irq_enable_r <= nvac_pkg::CTL_BIT_RESET;
        else if (ce && ctl_wr)
            ready_irq_enable_r <= io_wdata[nvac_pkg::CTL_RIE_BIT];
    end

    // unlock window, self-clearing
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            write_unlock_r <= nvac_pkg::CTL_BIT_RESET;
            unlock_cnt_r <= '0;
        end
        else if (ce)
        begin
            if (unlock_req)
            begin
                write_unlock_r <= 1'b1; // [RULE9]
                unlock_cnt_r <= 3'(nvac_pkg::UNLOCK_CYC);
            end
            else if (write_unlock_r)
            begin
                unlock_cnt_r <= unlock_cnt_r - 1'b1;
                if (unlock_cnt_r == 3'h1)
                    write_unlock_r <= 1'b0; // [RULE7]
            end
        end
    end

    // processor stall counter
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            stall_cnt_r <= '0;
        else if (ce)
        begin
            if (rd_go)
                stall_cnt_r <= 3'(nvac_pkg::READ_STALL_CYC); // [RULE14]
            else if (wr_go)
                stall_cnt_r <= 3'(nvac_pkg::WRITE_STALL_CYC); // [RULE13]
            else if (stall_cnt_r != 3'h0)
                stall_cnt_r <= stall_cnt_r - 1'b1;
        end
    end

    assign cpu_stall = (stall_cnt_r != 3'h0);

    // ready interrupt level
    assign nv_ready_irq = ready_irq_enable_r && irq_global_en && !write_strobe_busy; // [RULE6]

    // read mux; strobe-zero writes store nothing
    always_comb
    begin
        case (io_sel)
            nvac_pkg::REG_ADDR_LOW: io_rdata = nv_byte_address_r[7:0];
            nvac_pkg::REG_ADDR_HIGH: io_rdata = {7'h00, nv_byte_address_r[8]}; // [RULE2]
            nvac_pkg::REG_DATA: io_rdata = nv_data_byte_r;
            nvac_pkg::REG_CONTROL: io_rdata = {4'h0, ready_irq_enable_r, write_unlock_r,
                                               write_strobe_busy, 1'b0}; // [RULE5] [RULE17]
            default: io_rdata = 8'h00;
        endcase
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    sequence s_unlock_set;
        ce && unlock_req;
    endsequence

    sequence s_unlock_hold;
        (ce && !unlock_req)[*4];
    endsequence

    property p_unlock_expire;
        s_unlock_set ##1 s_unlock_hold |=> !write_unlock_r;
    endproperty
    a_unlock_expire: assert property (p_unlock_expire) // [RULE7]
        else $error("unlock did not expire");

    property p_unlock_live;
        s_unlock_set ##1 (ce && !unlock_req)[*3] |-> write_unlock_r;
    endproperty
    a_unlock_live: assert property (p_unlock_live) else $error("unlock dropped early"); // [RULE7]

    property p_launch_unlocked;
        $rose(write_strobe_busy) |-> $past(write_unlock_r) && !$past(flash_selfprog_active);
    endproperty
    a_launch_unlocked: assert property (p_launch_unlocked) // [RULE8] [RULE10]
        else $error("bad write launch");

    property p_no_unlock_no_write;
        ce && ctl_wr && !write_unlock_r && !write_strobe_busy |=> !write_strobe_busy;
    endproperty
    a_no_unlock_no_write: assert property (p_no_unlock_no_write) // [RULE8]
        else $error("locked write");

    property p_busy_end;
        $fell(write_strobe_busy) |-> $past(wr_if.done);
    endproperty
    a_busy_end: assert property (p_busy_end) else $error("busy cleared early"); // [RULE11]

    property p_zero_strobe;
        ce && ctl_wr && !io_wdata[nvac_pkg::CTL_WRITE_BIT] && !write_strobe_busy
            |=> !write_strobe_busy;
    endproperty
    a_zero_strobe: assert property (p_zero_strobe) else $error("zero strobe acted"); // [RULE17]

    property p_write_stall;
        ce && wr_go && !rd_go ##1 (ce && !io_wr)[*2] |=> !cpu_stall;
    endproperty
    a_write_stall: assert property (p_write_stall) else $error("write stall length"); // [RULE13]

    property p_read_stall;
        ce && rd_go |=> cpu_stall[*4];
    endproperty
    a_read_stall: assert property (p_read_stall) else $error("read stall short"); // [RULE14]

    property p_read_fetch;
        ce && rd_go |=> nv_data_byte_r == mem_r[$past(nv_byte_address_r)];
    endproperty
    a_read_fetch: assert property (p_read_fetch) else $error("read byte wrong"); // [RULE14]

    property p_busy_frozen;
        write_strobe_busy && io_sel != nvac_pkg::REG_DATA |=>
            $stable(nv_byte_address_r) && $stable(nv_data_byte_r);
    endproperty
    a_busy_frozen: assert property (p_busy_frozen) else $error("access during write"); // [RULE15]

    property p_store;
        ce && wr_if.done |=> mem_r[nv_byte_address_r] == $past(wr_byte_r);
    endproperty
    a_store: assert property (p_store) else $error("array not written"); // [RULE1]

    property p_irq_ready;
        $fell(write_strobe_busy) && ready_irq_enable_r && irq_global_en |-> nv_ready_irq;
    endproperty
    a_irq_ready: assert property (p_irq_ready) else $error("ready irq missing"); // [RULE6]

    property p_irq_busy;
        write_strobe_busy |-> !nv_ready_irq;
    endproperty
    a_irq_busy: assert property (p_irq_busy) else $error("irq while busy"); // [RULE6]

    property p_reserved;
        (io_sel == nvac_pkg::REG_ADDR_HIGH |-> io_rdata[7:1] == 7'h00)
        and (io_sel == nvac_pkg::REG_CONTROL |-> io_rdata[7:4] == 4'h0);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits set"); // [RULE2] [RULE5]

    property p_launch;
        ce && wr_go |=> write_strobe_busy;
    endproperty
    a_launch: assert property (p_launch) else $error("write not launched"); // [RULE8]

    property p_unlock_set;
        ce && unlock_req |=> write_unlock_r;
    endproperty
    a_unlock_set: assert property (p_unlock_set) else $error("unlock not set"); // [RULE7]

    property p_wr_stall_on;
        ce && wr_go && !rd_go |=> cpu_stall[*2];
    endproperty
    a_wr_stall_on: assert property (p_wr_stall_on) else $error("stall short"); // [RULE13]

    property p_flash_block;
        ce && ctl_wr && flash_selfprog_active && !write_strobe_busy |=> !write_strobe_busy;
    endproperty
    a_flash_block: assert property (p_flash_block) else $error("flash write"); // [RULE10]

    property p_read_blocked;
        ce && ctl_wr && io_wdata[nvac_pkg::CTL_READ_BIT] && write_strobe_busy
            |=> $stable(nv_data_byte_r);
    endproperty
    a_read_blocked: assert property (p_read_blocked) else $error("read ran"); // [RULE15]

    property p_addr_load;
        ce && addr_low_wr && !write_strobe_busy
            |=> nv_byte_address_r[7:0] == $past(io_wdata);
    endproperty
    a_addr_load: assert property (p_addr_load) else $error("address not loaded"); // [RULE2]
endmodule : nvac_ctrl

// ==== logic/nvac_pkg.sv ====
// Purpose: shared constants for the byte-wide nonvolatile array controller
// Assumes: 40 MHz core clock, 1 MHz write-timing oscillator derived from it
// Notes: register indices select one of the four I/O registers
package nvac_pkg;
    localparam int ARRAY_BYTES = 512;
    localparam int ADDR_W = 9;
    localparam int DATA_W = 8;

    // register indices on the I/O select port
    localparam logic [1:0] REG_ADDR_LOW = 2'h0;
    localparam logic [1:0] REG_ADDR_HIGH = 2'h1;
    localparam logic [1:0] REG_DATA = 2'h2;
    localparam logic [1:0] REG_CONTROL = 2'h3;

    // control register bit positions
    localparam int CTL_READ_BIT = 0;
    localparam int CTL_WRITE_BIT = 1;
    localparam int CTL_UNLOCK_BIT = 2;
    localparam int CTL_RIE_BIT = 3;
    // address high register field
    localparam int ADDR_HIGH_BIT = 0;

    // reset values
    localparam logic [8:0] ADDR_RESET = 9'h000;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic CTL_BIT_RESET = 1'b0;

    // timing
    localparam int UNLOCK_CYC = 4;
    localparam int READ_STALL_CYC = 4;
    localparam int WRITE_STALL_CYC = 2;
    localparam int CLK_HZ = 40_000_000;
    localparam int OSC_HZ = 1_000_000;
    localparam int OSC_DIV = (CLK_HZ + OSC_HZ - 1) / OSC_HZ;
    localparam int WRITE_OSC_CYC = 8448;

    typedef enum logic {WT_IDLE, WT_RUN} nvac_wstate_t;

    function automatic logic reg_hit(input logic [1:0] sel, input logic [1:0] idx,
                                     input logic wr);
        reg_hit = wr && (sel == idx);
    endfunction : reg_hit
endpackage : nvac_pkg

// ==== logic/nvac_wr_if.sv ====
// Purpose: handshake between controller and write timer
// Assumes: single clock domain
// Notes: start and done are one-cycle pulses
`timescale 1ns/1ps
interface nvac_wr_if;
    logic start;
    logic busy;
    logic done;
    modport ctrl (output start, input busy, input done);
    modport timer (input start, output busy, output done);
endinterface : nvac_wr_if

// ==== logic/nvac_wr_timer.sv ====
// Purpose: self-timed write duration from a divided 1 MHz tick
// Assumes: start only while idle
// Notes: done pulses in the last cycle of the write
`timescale 1ns/1ps
module nvac_wr_timer #(
    parameter int OSC_DIV = nvac_pkg::OSC_DIV,
    parameter int WRITE_OSC_CYC = nvac_pkg::WRITE_OSC_CYC
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    nvac_wr_if.timer wr
);
    localparam int DIV_W = $clog2(OSC_DIV + 1);
    localparam int OSC_W = $clog2(WRITE_OSC_CYC + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(OSC_DIV - 1);
    localparam logic [OSC_W-1:0] OSC_LAST = OSC_W'(WRITE_OSC_CYC - 1);

    nvac_pkg::nvac_wstate_t state_r;
    logic [DIV_W-1:0] div_r;
    logic [OSC_W-1:0] osc_r;
    logic tick;

    assign tick = (div_r == DIV_LAST);
    assign wr.busy = (state_r == nvac_pkg::WT_RUN);
    assign wr.done = ce && wr.busy && tick && (osc_r == OSC_LAST);

    // write length in oscillator ticks [RULE12]
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_r <= nvac_pkg::WT_IDLE;
            div_r <= '0;
            osc_r <= '0;
        end
        else if (ce)
        begin
            case (state_r)
                nvac_pkg::WT_IDLE:
                begin
                    div_r <= '0;
                    osc_r <= '0;
                    if (wr.start)
                        state_r <= nvac_pkg::WT_RUN;
                end
                nvac_pkg::WT_RUN:
                begin
                    div_r <= tick ? '0 : div_r + 1'b1;
                    if (tick)
                        osc_r <= osc_r + 1'b1;
                    if (wr.done)
                        state_r <= nvac_pkg::WT_IDLE;
                end
                default: state_r <= nvac_pkg::WT_IDLE;
            endcase
        end
    end

    property p_timer_len;
        @(posedge clk) disable iff (!arst_n)
        wr.done |-> (osc_r == OSC_LAST) && (div_r == DIV_LAST) && wr.busy;
    endproperty
    a_timer_len: assert property (p_timer_len) else $error("write ended early"); // [RULE12]
endmodule : nvac_wr_timer

// ==== bench/nvac_cpu_model.sv ====
// Purpose: processor-side model issuing I/O register accesses to the controller
// Assumes: inputs driven at falling clock edge, io_rdata settled 1 ns later
// Notes: write data is inverted once the write strobe is released
`timescale 1ns/1ps
module nvac_cpu_model (
    input wire logic clk,
    input wire logic [7:0] io_rdata,
    output logic [1:0] io_sel,
    output logic io_wr,
    output logic [7:0] io_wdata,
    output logic irq_global_en,
    output logic flash_selfprog_active
);
    initial
    begin
        io_sel = 2'h0;
        io_wr = 1'b0;
        io_wdata = 8'h00;
        irq_global_en = 1'b0;
        flash_selfprog_active = 1'b0;
    end

    task automatic reg_wr(input logic [1:0] sel, input logic [7:0] d);
        @(negedge clk);
        io_sel = sel;
        io_wdata = d;
        io_wr = 1'b1;
        @(negedge clk);
        io_wr = 1'b0;
        io_wdata = ~d;
    endtask : reg_wr

    task automatic reg_rd(input logic [1:0] sel, output logic [7:0] d);
        @(negedge clk);
        io_sel = sel;
        #1;
        d = io_rdata;
    endtask : reg_rd

    task automatic set_lines(input logic gie, input logic flash);
        @(negedge clk);
        irq_global_en = gie;
        flash_selfprog_active = flash;
    endtask : set_lines

    // poll busy until clear, bounded
    task automatic wait_idle();
        logic [7:0] v;
        v = 8'hFF;
        for (int i = 0; i < 200 && v[1] !== 1'b0; i++)
        begin
            reg_rd(nvac_pkg::REG_CONTROL, v);
        end
    endtask : wait_idle

    // full write: idle wait, address, data, unlock, strobe
    task automatic write_seq(input logic [8:0] a, input logic [7:0] d, input logic rie);
        set_lines(1'b0, 1'b0);
        wait_idle();
        reg_wr(nvac_pkg::REG_ADDR_HIGH, {7'h00, a[8]});
        reg_wr(nvac_pkg::REG_ADDR_LOW, a[7:0]);
        reg_wr(nvac_pkg::REG_DATA, d);
        reg_wr(nvac_pkg::REG_CONTROL, {4'h0, rie, 3'b100});
        reg_wr(nvac_pkg::REG_CONTROL, {4'h0, rie, 3'b110});
    endtask : write_seq
endmodule : nvac_cpu_model

// ==== bench/nvac_ctrl_tb.sv ====
// Purpose: self-checking bench for the nonvolatile byte access controller
// Assumes: shortened write time, OSC_DIV 2 and 8 ticks, 16 cycles
// Notes: ce dropped in one scenario; array holds no reset value
`timescale 1ns/1ps
module nvac_ctrl_tb;
    localparam int WR_CYC = 16;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic ce = 1'b1;
    logic [1:0] io_sel;
    logic io_wr;
    logic [7:0] io_wdata;
    logic [7:0] io_rdata;
    logic irq_global_en;
    logic flash_selfprog_active;
    logic cpu_stall;
    logic nv_ready_irq;
    int miscompares = 0;
    int checks_done = 0;

    always #12.5 clk = ~clk;

    nvac_ctrl #(.OSC_DIV(2), .WRITE_OSC_CYC(8)) dut_u (.clk(clk), .arst_n(arst_n), .ce(ce),
        .io_sel(io_sel), .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .irq_global_en(irq_global_en), .flash_selfprog_active(flash_selfprog_active),
        .cpu_stall(cpu_stall), .nv_ready_irq(nv_ready_irq));

    nvac_cpu_model cpu_u (.clk(clk), .io_rdata(io_rdata), .io_sel(io_sel), .io_wr(io_wr),
        .io_wdata(io_wdata), .irq_global_en(irq_global_en),
        .flash_selfprog_active(flash_selfprog_active));

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic close_out();
        if (miscompares == 0 && checks_done > 0)
        begin
            $display("bench passed");
        end
        else
        begin
            $display("bench failed");
        end
        $finish;
    endtask : close_out

    // counts stall cycles from the current falling edge
    task automatic count_stall(output int n);
        n = 0;
        while (cpu_stall === 1'b1 && n < 20)
        begin
            n++;
            @(negedge clk);
        end
    endtask : count_stall

    task automatic t_reset();
        logic [7:0] v;
        for (int r = 0; r < 4; r++)
        begin
            cpu_u.reg_rd(r[1:0], v);
            check("reset reg", {8'h00, v}, 16'h0000);
        end
        cpu_u.reg_wr(nvac_pkg::REG_ADDR_HIGH, 8'hFF);
        cpu_u.reg_rd(nvac_pkg::REG_ADDR_HIGH, v);
        check("addr high", {8'h00, v}, 16'h0001);
        cpu_u.reg_wr(nvac_pkg::REG_CONTROL, 8'hF0);
        cpu_u.reg_rd(nvac_pkg::REG_CONTROL, v);
        check("ctl reserved", {8'h00, v}, 16'h0000);
    endtask : t_reset

    task automatic t_write();
        logic [7:0] v;
        int nb;
        int ns;
        nb = 0;
        ns = 0;
        cpu_u.write_seq(9'h1FF, 8'hA5, 1'b1);
        for (int i = 0; i < 40; i++)
        begin
            #1;
            nb += (io_rdata[1] === 1'b1);
            ns += (cpu_stall === 1'b1);
            if (io_rdata[1] === 1'b1)
                check("irq busy", {15'h0, nv_ready_irq}, 16'h0000);
            @(negedge clk);
        end
        check("busy cycles", nb[15:0], WR_CYC[15:0]);
        check("write stall", ns[15:0], 16'h0002);
        check("irq gie off", {15'h0, nv_ready_irq}, 16'h0000);
        cpu_u.set_lines(1'b1, 1'b0);
        #1;
        check("irq ready", {15'h0, nv_ready_irq}, 16'h0001);
        cpu_u.set_lines(1'b0, 1'b0);
        cpu_u.reg_wr(nvac_pkg::REG_DATA, 8'h00);
        cpu_u.reg_wr(nvac_pkg::REG_CONTROL, 8'h01);
        count_stall(ns);
        check("read stall", ns[15:0], 16'h0004);
        cpu_u.reg_rd(nvac_pkg::REG_DATA, v);
        check("read back", {8'h00, v}, 16'h00A5);
    endtask : t_write

    task automatic t_busy_block();
        logic [7:0] v;
        cpu_u.write_seq(9'h000, 8'h5A, 1'b0);
        cpu_u.reg_wr(nvac_pkg::REG_ADDR_LOW, 8'h77);
        cpu_u.reg_rd(nvac_pkg::REG_ADDR_LOW, v);
        check("addr locked", {8'h00, v}, 16'h0000);
        cpu_u.reg_wr(nvac_pkg::REG_CONTROL, 8'h00);
        cpu_u.reg_rd(nvac_pkg::REG_CONTROL, v);
        check("zero strobe", {8'h00, v & 8'h02}, 16'h0002);
        cpu_u.reg_wr(nvac_pkg::REG_DATA, 8'h11);
        cpu_u.reg_wr(nvac_pkg::REG_CONTROL, 8'h01);
        cpu_u.reg_rd(nvac_pkg::REG_DATA, v);
        check("read blocked", {8'h00, v}, 16'h0011);
        cpu_u.wait_idle();
        cpu_u.reg_wr(nvac_pkg::REG_CONTROL, 8'h01);
        cpu_u.reg_rd(nvac_pkg::REG_DATA, v);
        check("latched byte", {8'h00, v}, 16'h005A);
    endtask : t_busy_block

    task automatic t_unlock();
        logic [7:0] v;
        cpu_u.reg_wr(nvac_pkg::REG_CONTROL, 8'h02);
        cpu_u.reg_rd(nvac_pkg::REG_CONTROL, v);
        check("strobe locked", {8'h00, v}, 16'h0000);
        cpu_u.reg_wr(nvac_pkg::REG_CONTROL, 8'h04);
        for (int i = 0; i < 5; i++)
        begin
            #1;
            check("unlock bit", {15'h0, io_rdata[2]}, {15'h0, i < 4});
            @(negedge clk);
        end
        cpu_u.reg_wr(nvac_pkg::REG_CONTROL, 8'h02);
        cpu_u.reg_rd(nvac_pkg::REG_CONTROL, v);
        check("expired strobe", {8'h00, v}, 16'h0000);
    endtask : t_unlock

    task automatic t_flash();
        logic [7:0] v;
        cpu_u.set_lines(1'b0, 1'b1);
        cpu_u.reg_wr(nvac_pkg::REG_CONTROL, 8'h04);
        cpu_u.reg_wr(nvac_pkg::REG_CONTROL, 8'h06);
        cpu_u.reg_rd(nvac_pkg::REG_CONTROL, v);
        check("flash block", {8'h00, v & 8'h02}, 16'h0000);
        cpu_u.set_lines(1'b0, 1'b0);
    endtask : t_flash

    // ce low freezes unlock window and write timer
    task automatic t_freeze();
        cpu_u.reg_wr(nvac_pkg::REG_CONTROL, 8'h04);
        ce = 1'b0;
        repeat (6) @(negedge clk);
        ce = 1'b1;
        #1;
        check("frozen unlock", {15'h0, io_rdata[2]}, 16'h0001);
        cpu_u.reg_wr(nvac_pkg::REG_CONTROL, 8'h0A);
        cpu_u.set_lines(1'b1, 1'b0);
        ce = 1'b0;
        repeat (WR_CYC + 4) @(negedge clk);
        ce = 1'b1;
        #1;
        check("frozen busy", {15'h0, io_rdata[1]}, 16'h0001);
        check("irq busy gie", {15'h0, nv_ready_irq}, 16'h0000);
        cpu_u.wait_idle();
        #1;
        check("idle after", {15'h0, io_rdata[1]}, 16'h0000);
        check("irq level", {15'h0, nv_ready_irq}, 16'h0001);
        cpu_u.set_lines(1'b0, 1'b0);
    endtask : t_freeze

    initial
    begin
        repeat (5) @(posedge clk);
        @(negedge clk);
        arst_n = 1'b1;
        t_reset();
        t_write();
        t_busy_block();
        t_unlock();
        t_flash();
        t_freeze();
        close_out();
    end

    initial
    begin
        repeat (4000) @(posedge clk);
        miscompares++;
        close_out();
    end
endmodule : nvac_ctrl_tb
